//--- hw/uartc_pkg.sv
// uartc_pkg: constants and types shared by the uart channel core
package uartc_pkg;
  // ----------------------------------------------------------------
  // register map (A2..A0)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IE = 3'h1;
  localparam logic [2:0] ADDR_IS = 3'h2;
  localparam logic [2:0] ADDR_LC = 3'h3;
  localparam logic [2:0] ADDR_MC = 3'h4;
  localparam logic [2:0] ADDR_LS = 3'h5;
  localparam logic [2:0] ADDR_MS = 3'h6;
  localparam logic [2:0] ADDR_SP = 3'h7;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LC_DIV_EN = 7;
  localparam int LC_BREAK = 6;
  localparam int LC_STICK = 5;
  localparam int LC_EVEN = 4;
  localparam int LC_PAR_EN = 3;
  localparam int LC_STOP2 = 2;
  localparam int MC_LOOP = 4;
  localparam int MC_OP2 = 3;
  localparam int MC_OP1 = 2;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  // ----------------------------------------------------------------
  // reset values and interrupt codes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [3:0] IS_NONE = 4'h1;
  localparam logic [3:0] IS_LINE = 4'h6;
  localparam logic [3:0] IS_RX = 4'h4;
  localparam logic [3:0] IS_TX = 4'h2;
  localparam logic [3:0] IS_MODEM = 4'h0;
  // ----------------------------------------------------------------
  // timing counts in 16x ticks
  // ----------------------------------------------------------------
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] START_LAST = 4'(OVERSAMPLE / 2 - 1);
  typedef enum logic [2:0] {
    UARTC_IDLE = 3'h0, UARTC_START = 3'h1, UARTC_DATA = 3'h3,
    UARTC_PARITY = 3'h2, UARTC_STOP = 3'h6
  } uartc_state_t;
endpackage

//--- hw/uartc_channel_core.sv
// uartc_channel_core: one asynchronous serial channel with its register set
`timescale 1ns/10ps
module uartc_channel_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chanSelectN,
  input wire logic [2:0] busAddr,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  output logic busDataOe,
  output logic serTxOut,
  input wire logic serRxIn,
  output logic requestToSendN,
  output logic termReadyN,
  output logic op1N,
  output logic op2N,
  input wire logic clearToSendN,
  input wire logic setReadyN,
  input wire logic carrierDetectN,
  input wire logic ringIndicatorN,
  output logic intReq
);
  // ----------------------------------------------------------------
  // shared functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] maskData(input logic [7:0] d, input logic [1:0] wl);
    maskData = d & (8'hFF >> (3'h3 - {1'b0, wl}));
  endfunction
  function automatic logic parityOf(input logic [7:0] d, input logic [7:0] lc);
    if (lc[uartc_pkg::LC_STICK]) begin
      parityOf = ~lc[uartc_pkg::LC_EVEN];
    end else begin
      parityOf = (^maskData(d, lc[1:0])) ^ ~lc[uartc_pkg::LC_EVEN];
    end
  endfunction
  // start is checked after half a bit, every later bit after a whole one
  function automatic logic [3:0] TICK_SEL(input uartc_pkg::uartc_state_t s);
    TICK_SEL = (s == uartc_pkg::UARTC_START) ? uartc_pkg::START_LAST : uartc_pkg::TICK_LAST;
  endfunction

  // ----------------------------------------------------------------
  // host bus and registers
  // ----------------------------------------------------------------
  logic [7:0] lineCtrl_reg, modemCtrl_reg, intEnable_reg, scratchPad_reg;
  logic [15:0] divisor_reg;
  logic rdPrev_reg, wrPrev_reg;
  logic rdTake, wrTake, divAccess, loopOn;
  logic [7:0] rdMux;
  logic [3:0] isCode;
  // host strobes share ref_clk; one action per strobe falling edge
  assign rdTake = !chanSelectN && !readStrobeN && rdPrev_reg;
  assign wrTake = !chanSelectN && !writeStrobeN && wrPrev_reg;
  assign divAccess = lineCtrl_reg[uartc_pkg::LC_DIV_EN];
  assign loopOn = modemCtrl_reg[uartc_pkg::MC_LOOP];
  assign busDataOe = !chanSelectN && !readStrobeN;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPrev_reg <= 1'b1;
      wrPrev_reg <= 1'b1;
    end else begin
      rdPrev_reg <= chanSelectN || readStrobeN;
      wrPrev_reg <= chanSelectN || writeStrobeN;
    end
  end

  // status addresses take no write: no case item for them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineCtrl_reg <= uartc_pkg::REG_RST;
      modemCtrl_reg <= uartc_pkg::REG_RST;
      intEnable_reg <= uartc_pkg::REG_RST;
      scratchPad_reg <= uartc_pkg::REG_RST;
      divisor_reg <= uartc_pkg::DIV_RST;
    end else if (wrTake) begin
      case (busAddr)
        uartc_pkg::ADDR_DATA: begin
          if (divAccess) begin
            divisor_reg[7:0] <= busWrData;
          end
        end
        uartc_pkg::ADDR_IE: begin
          if (divAccess) begin
            divisor_reg[15:8] <= busWrData;
          end else begin
            intEnable_reg <= {4'h0, busWrData[3:0]};
          end
        end
        uartc_pkg::ADDR_LC: lineCtrl_reg <= busWrData;
        uartc_pkg::ADDR_MC: modemCtrl_reg <= {3'h0, busWrData[4:0]};
        uartc_pkg::ADDR_SP: scratchPad_reg <= busWrData;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers: rx, cts, dsr, ri, cd
  // ----------------------------------------------------------------
  logic [4:0] pinS1_reg, pinS2_reg, pinS3_reg, pinStable_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_reg <= 5'h1F;
      pinS2_reg <= 5'h1F;
      pinS3_reg <= 5'h1F;
      pinStable_reg <= 5'h1F;
    end else begin
      pinS1_reg <= {carrierDetectN, ringIndicatorN, setReadyN, clearToSendN, serRxIn};
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pinStable_reg <= (pinS2_reg & ~(pinS2_reg ^ pinS3_reg))
                     | (pinStable_reg & (pinS2_reg ^ pinS3_reg));
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  logic [15:0] baudCnt_reg, divEff;
  logic tick16;
  // a zero divisor would stall the channel, so it runs as one
  assign divEff = (divisor_reg == 16'h0000) ? 16'h0001 : divisor_reg;
  // terminal-count compare lets a new divisor act within one tick period
  assign tick16 = (baudCnt_reg >= divEff - 16'h0001);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_reg <= 16'h0000;
    end else if (tick16) begin
      baudCnt_reg <= 16'h0000;
    end else begin
      baudCnt_reg <= baudCnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  uartc_pkg::uartc_state_t txState_reg;
  logic [7:0] txHold_reg, txShift_reg;
  logic txHoldEmpty_reg, txLine_reg, txParity_reg, txStop2_reg;
  logic [3:0] txTick_reg;
  logic [2:0] txBit_reg;
  logic txLoad, txBitEnd, txWrite, txLineInt;
  assign txWrite = wrTake && busAddr == uartc_pkg::ADDR_DATA && !divAccess;
  assign txLoad = txState_reg == uartc_pkg::UARTC_IDLE && !txHoldEmpty_reg;
  assign txBitEnd = tick16 && txTick_reg == uartc_pkg::TICK_LAST;
  assign txLineInt = txLine_reg && !lineCtrl_reg[uartc_pkg::LC_BREAK];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txHold_reg <= 8'h00;
      txHoldEmpty_reg <= 1'b1;
    end else if (txWrite) begin
      txHold_reg <= busWrData;
      txHoldEmpty_reg <= 1'b0;
    end else if (txLoad) begin
      txHoldEmpty_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_reg <= uartc_pkg::UARTC_IDLE;
      txShift_reg <= 8'h00;
      txLine_reg <= 1'b1;
      txTick_reg <= 4'h0;
      txBit_reg <= 3'h0;
      txParity_reg <= 1'b0;
      txStop2_reg <= 1'b0;
    end else begin
      if (tick16) begin
        txTick_reg <= txTick_reg + 4'h1;
      end
      case (txState_reg)
        uartc_pkg::UARTC_IDLE: begin
          txLine_reg <= 1'b1;
          if (txLoad) begin
            txShift_reg <= txHold_reg;
            txParity_reg <= parityOf(txHold_reg, lineCtrl_reg);
            txStop2_reg <= lineCtrl_reg[uartc_pkg::LC_STOP2];
            txLine_reg <= 1'b0;
            txTick_reg <= 4'h0;
            txState_reg <= uartc_pkg::UARTC_START;
          end
        end
        uartc_pkg::UARTC_START: begin
          if (txBitEnd) begin
            txLine_reg <= txShift_reg[0];
            txBit_reg <= 3'h0;
            txState_reg <= uartc_pkg::UARTC_DATA;
          end
        end
        uartc_pkg::UARTC_DATA: begin
          if (txBitEnd) begin
            if (txBit_reg == {1'b1, lineCtrl_reg[1:0]}) begin
              if (lineCtrl_reg[uartc_pkg::LC_PAR_EN]) begin
                txLine_reg <= txParity_reg;
                txState_reg <= uartc_pkg::UARTC_PARITY;
              end else begin
                txLine_reg <= 1'b1;
                txState_reg <= uartc_pkg::UARTC_STOP;
              end
            end else begin
              txShift_reg <= {1'b0, txShift_reg[7:1]};
              txLine_reg <= txShift_reg[1];
              txBit_reg <= txBit_reg + 3'h1;
            end
          end
        end
        uartc_pkg::UARTC_PARITY: begin
          if (txBitEnd) begin
            txLine_reg <= 1'b1;
            txState_reg <= uartc_pkg::UARTC_STOP;
          end
        end
        uartc_pkg::UARTC_STOP: begin
          if (txBitEnd) begin
            if (txStop2_reg) begin
              txStop2_reg <= 1'b0;
            end else begin
              txState_reg <= uartc_pkg::UARTC_IDLE;
            end
          end
        end
        default: txState_reg <= uartc_pkg::UARTC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  uartc_pkg::uartc_state_t rxState_reg;
  logic [7:0] rxShift_reg, rxHold_reg;
  logic [3:0] rxTick_reg;
  logic [2:0] rxBit_reg;
  logic rxLinePrev_reg, rxParErr_reg, rxReady_reg, overrun_reg;
  logic [2:0] rxTags_reg;
  logic rxLine, rxSample, rxPush, rxRead, lsRead;
  logic [7:0] rxData;
  assign rxLine = loopOn ? txLineInt : pinStable_reg[0];
  assign rxSample = tick16 && rxTick_reg == TICK_SEL(rxState_reg);
  assign rxData = maskData(rxShift_reg >> (3'h3 - {1'b0, lineCtrl_reg[1:0]}), lineCtrl_reg[1:0]);
  assign rxRead = rdTake && busAddr == uartc_pkg::ADDR_DATA && !divAccess;
  assign lsRead = rdTake && busAddr == uartc_pkg::ADDR_LS;
  assign rxPush = rxState_reg == uartc_pkg::UARTC_STOP && rxSample;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_reg <= uartc_pkg::UARTC_IDLE;
      rxShift_reg <= 8'h00;
      rxTick_reg <= 4'h0;
      rxBit_reg <= 3'h0;
      rxParErr_reg <= 1'b0;
      rxLinePrev_reg <= 1'b1;
    end else begin
      rxLinePrev_reg <= rxLine;
      if (tick16) begin
        rxTick_reg <= rxTick_reg + 4'h1;
      end
      if (rxSample) begin
        rxTick_reg <= 4'h0;
      end
      case (rxState_reg)
        uartc_pkg::UARTC_IDLE: begin
          if (rxLinePrev_reg && !rxLine) begin
            rxTick_reg <= 4'h0;
            rxState_reg <= uartc_pkg::UARTC_START;
          end
        end
        uartc_pkg::UARTC_START: begin
          if (rxSample) begin
            rxBit_reg <= 3'h0;
            rxParErr_reg <= 1'b0;
            // a high line here was a glitch, not a start bit
            rxState_reg <= rxLine ? uartc_pkg::UARTC_IDLE : uartc_pkg::UARTC_DATA;
          end
        end
        uartc_pkg::UARTC_DATA: begin
          if (rxSample) begin
            rxShift_reg <= {rxLine, rxShift_reg[7:1]};
            rxBit_reg <= rxBit_reg + 3'h1;
            if (rxBit_reg == {1'b1, lineCtrl_reg[1:0]}) begin
              rxState_reg <= lineCtrl_reg[uartc_pkg::LC_PAR_EN] ?
                uartc_pkg::UARTC_PARITY : uartc_pkg::UARTC_STOP;
            end
          end
        end
        uartc_pkg::UARTC_PARITY: begin
          if (rxSample) begin
            rxParErr_reg <= rxLine != parityOf(rxData, lineCtrl_reg);
            rxState_reg <= uartc_pkg::UARTC_STOP;
          end
        end
        uartc_pkg::UARTC_STOP: begin
          if (rxSample) begin
            rxState_reg <= uartc_pkg::UARTC_IDLE;
          end
        end
        default: rxState_reg <= uartc_pkg::UARTC_IDLE;
      endcase
    end
  end

  // holding stage: byte plus break, framing and parity tags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxHold_reg <= 8'h00;
      rxTags_reg <= 3'h0;
      rxReady_reg <= 1'b0;
    end else if (rxPush) begin
      rxHold_reg <= rxData;
      rxTags_reg <= {rxData == 8'h00 && !rxLine, !rxLine, rxParErr_reg};
      rxReady_reg <= 1'b1;
    end else if (rxRead) begin
      rxReady_reg <= 1'b0;
      rxTags_reg <= 3'h0;
    end
  end

  // overrun: set wins over the clear made by a status read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (rxPush && rxReady_reg && !rxRead) begin
      overrun_reg <= 1'b1;
    end else if (lsRead) begin
      overrun_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // modem status and interrupt source
  // ----------------------------------------------------------------
  logic [3:0] modemIn, modemPrev_reg, modemDelta_reg;
  logic txIntPend_reg, txEmptyPrev_reg, txIeOnPrev_reg;
  logic [7:0] lineStatus, modemStatus;
  // loopback drives the modem inputs from control bits instead of pins
  assign modemIn = loopOn ?
    {modemCtrl_reg[uartc_pkg::MC_OP2], modemCtrl_reg[uartc_pkg::MC_OP1],
     modemCtrl_reg[uartc_pkg::MC_DTR], modemCtrl_reg[uartc_pkg::MC_RTS]}
    : ~pinStable_reg[4:1];
  assign lineStatus = {1'b0, txHoldEmpty_reg && txState_reg == uartc_pkg::UARTC_IDLE,
                       txHoldEmpty_reg, rxTags_reg, overrun_reg, rxReady_reg};
  assign modemStatus = {modemIn, modemDelta_reg};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modemPrev_reg <= 4'h0;
      modemDelta_reg <= 4'h0;
    end else begin
      modemPrev_reg <= modemIn;
      modemDelta_reg <= (rdTake && busAddr == uartc_pkg::ADDR_MS ? 4'h0 : modemDelta_reg)
                      | ((modemIn ^ modemPrev_reg) & {2'b11, ~modemIn[2], 1'b1});
    end
  end

  always_comb begin
    if (intEnable_reg[uartc_pkg::IE_LINE] && (overrun_reg || rxTags_reg != 3'h0)) begin
      isCode = uartc_pkg::IS_LINE;
    end else if (intEnable_reg[uartc_pkg::IE_RX] && rxReady_reg) begin
      isCode = uartc_pkg::IS_RX;
    end else if (intEnable_reg[uartc_pkg::IE_TX] && txIntPend_reg) begin
      isCode = uartc_pkg::IS_TX;
    end else if (intEnable_reg[uartc_pkg::IE_MODEM] && modemDelta_reg != 4'h0) begin
      isCode = uartc_pkg::IS_MODEM;
    end else begin
      isCode = uartc_pkg::IS_NONE;
    end
  end

  // tx interrupt arms on empty or on enabling while empty; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txIntPend_reg <= 1'b0;
      txEmptyPrev_reg <= 1'b1;
      txIeOnPrev_reg <= 1'b0;
    end else begin
      txEmptyPrev_reg <= txHoldEmpty_reg;
      txIeOnPrev_reg <= intEnable_reg[uartc_pkg::IE_TX];
      if (txHoldEmpty_reg && (!txEmptyPrev_reg
          || (intEnable_reg[uartc_pkg::IE_TX] && !txIeOnPrev_reg))) begin
        txIntPend_reg <= 1'b1;
      end else if (txWrite || (rdTake && busAddr == uartc_pkg::ADDR_IS
                   && isCode == uartc_pkg::IS_TX)) begin
        txIntPend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  always_comb begin
    case (busAddr)
      uartc_pkg::ADDR_DATA: rdMux = divAccess ? divisor_reg[7:0] : rxHold_reg;
      uartc_pkg::ADDR_IE: rdMux = divAccess ? divisor_reg[15:8] : intEnable_reg;
      uartc_pkg::ADDR_IS: rdMux = {4'h0, isCode};
      uartc_pkg::ADDR_LC: rdMux = lineCtrl_reg;
      uartc_pkg::ADDR_MC: rdMux = modemCtrl_reg;
      uartc_pkg::ADDR_LS: rdMux = lineStatus;
      uartc_pkg::ADDR_MS: rdMux = modemStatus;
      uartc_pkg::ADDR_SP: rdMux = scratchPad_reg;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdData <= 8'h00;
      serTxOut <= 1'b1;
      requestToSendN <= 1'b1;
      termReadyN <= 1'b1;
      op1N <= 1'b1;
      op2N <= 1'b1;
      intReq <= 1'b0;
    end else begin
      if (rdTake) begin
        busRdData <= rdMux;
      end
      serTxOut <= loopOn ? 1'b1 : txLineInt;
      requestToSendN <= loopOn || !modemCtrl_reg[uartc_pkg::MC_RTS];
      termReadyN <= loopOn || !modemCtrl_reg[uartc_pkg::MC_DTR];
      op1N <= loopOn || !modemCtrl_reg[uartc_pkg::MC_OP1];
      op2N <= loopOn || !modemCtrl_reg[uartc_pkg::MC_OP2];
      intReq <= isCode != uartc_pkg::IS_NONE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [15:0] gapCnt_reg;
  logic gapValid_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_reg <= 16'h0000;
      gapValid_reg <= 1'b0;
    end else begin
      gapCnt_reg <= tick16 ? 16'h0001 : gapCnt_reg + 16'h0001;
      gapValid_reg <= wrTake ? 1'b0 : (gapValid_reg || tick16);
    end
  end

  sequence s_tx_accept;
    txLoad && !txWrite;
  endsequence
  sequence s_sp_write;
    wrTake && busAddr == uartc_pkg::ADDR_SP;
  endsequence

  a_baud_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick16 && gapValid_reg && !$past(wrTake) |-> gapCnt_reg == divEff)
    else $error("tick spacing differs from divisor");
  a_hold_empty_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_tx_accept |=> txHoldEmpty_reg && txState_reg == uartc_pkg::UARTC_START)
    else $error("holding byte not moved to shifter");
  a_bit_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
    txState_reg != uartc_pkg::UARTC_IDLE && !txBitEnd && !txLoad |=> $stable(txLine_reg))
    else $error("tx line changed inside a bit");
  a_shift_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(lineStatus[6]) |-> $past(txState_reg) == uartc_pkg::UARTC_STOP)
    else $error("shifter empty flag before last stop bit");
  a_false_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rxState_reg == uartc_pkg::UARTC_START && rxSample && rxLine
    |=> rxState_reg == uartc_pkg::UARTC_IDLE)
    else $error("false start accepted");
  a_rx_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rxPush |=> rxReady_reg ##0 lineStatus[0])
    else $error("data ready not set");
  a_rx_int: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rxPush && intEnable_reg[uartc_pkg::IE_RX] && !intEnable_reg[uartc_pkg::IE_LINE]
    |=> ##1 intReq)
    else $error("receive interrupt missing");
  a_loop_tx_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    loopOn [*2] |-> serTxOut && requestToSendN && termReadyN)
    else $error("loopback outputs not idle");
  a_scratch_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_sp_write ##3 (rdTake && busAddr == uartc_pkg::ADDR_SP)
    |=> busRdData == $past(busWrData, 4))
    else $error("scratch pad lost value");
endmodule

//--- tb/uartc_far_end.sv
// far-end serial device model for the channel bench
`timescale 1ns/10ps
module uartc_far_end (
  input wire logic ref_clk,
  input wire logic serTxOut,
  output logic serRxIn
);
  // line idles at mark so leaving loopback never shows a break
  initial serRxIn = 1'b1;
  task automatic send(input logic [7:0] d, input int bitClk);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serRxIn = f[i];
      repeat (bitClk) @(posedge ref_clk);
      #2;
    end
  endtask
  // short low pulse that the receiver must reject
  task automatic glitch(input int n);
    serRxIn = 1'b0;
    repeat (n) @(posedge ref_clk);
    #2;
    serRxIn = 1'b1;
  endtask
  // bounded hunt for the start edge, then mid-bit sampling off the edge
  task automatic grab(output logic [7:0] d, output logic late, input int bitClk);
    int n;
    n = 0;
    while (serTxOut !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    late = n >= 5000;
    repeat (bitClk / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitClk) @(posedge ref_clk);
      #2;
      d[i] = serTxOut;
    end
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the uart channel core
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 0, rst_n = 0, selN = 1, rdN = 1, wrN = 1, serRxIn, serTxOut;
  logic rtsN, dtrN, intReq, oe, o1N, o2N, late;
  logic [2:0] busAddr = 3'h0;
  logic [7:0] busWrData = 8'h00, busRdData, q, g;
  int errCount = 0, checkCount = 0;
  logic [18:0] rows [9] = '{{3'h3, 8'h83, 8'h83}, {3'h0, 8'h18, 8'h18}, {3'h1, 8'h00, 8'h00},
    {3'h7, 8'hA5, 8'hA5}, {3'h3, 8'h03, 8'h03}, {3'h1, 8'h01, 8'h01}, {3'h4, 8'h03, 8'h03},
    {3'h5, 8'hFF, 8'h60}, {3'h2, 8'hFF, 8'h01}};
  always #12.5 ref_clk = ~ref_clk;
  uartc_channel_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .chanSelectN(selN),
    .busAddr(busAddr), .readStrobeN(rdN), .writeStrobeN(wrN), .busWrData(busWrData),
    .busRdData(busRdData), .busDataOe(oe), .serTxOut(serTxOut), .serRxIn(serRxIn),
    .requestToSendN(rtsN), .termReadyN(dtrN), .op1N(o1N), .op2N(o2N), .clearToSendN(1'b1),
    .setReadyN(1'b1), .carrierDetectN(1'b1), .ringIndicatorN(1'b1), .intReq(intReq));
  uartc_far_end far (.ref_clk(ref_clk), .serTxOut(serTxOut), .serRxIn(serRxIn));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checkCount++;
    if (s !== e) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access: strobe low over one take edge, data sampled an edge later
  task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w,
                     output logic [7:0] r);
    @(posedge ref_clk);
    #2;
    selN = 0;
    busAddr = a;
    busWrData = d;
    wrN = !w;
    rdN = w;
    @(posedge ref_clk);
    #2;
    if (!w) begin
      chk("read enable", {7'h0, oe}, 8'h01);
    end
    wrN = 1;
    rdN = 1;
    selN = 1;
    @(posedge ref_clk);
    #2;
    r = busRdData;
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic pollRdy();
    for (int i = 0; i < 200; i++) begin
      acc(3'h5, 8'h00, 0, q);
      if (q[0] === 1'b1) return;
      repeat (40) @(posedge ref_clk);
    end
    errCount++;
    wrapUp();
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    chk("tx idle in reset", {7'h0, serTxOut}, 8'h01);
    chk("read data in reset", busRdData, 8'h00);
    #2;
    rst_n = 1;
    repeat (2) @(posedge ref_clk);
    foreach (rows[i]) begin
      acc(rows[i][18:16], rows[i][15:8], 1, q);
      acc(rows[i][18:16], 8'h00, 0, q);
      chk("register row", q, rows[i][7:0]);
    end
    chk("modem outs", {4'h0, o2N, o1N, rtsN, dtrN}, 8'h0C);
    fork
      far.grab(g, late, 384);
      acc(3'h0, 8'h5A, 1, q);
    join
    if (late) begin
      errCount++;
      wrapUp();
    end
    chk("tx byte", g, 8'h5A);
    acc(3'h5, 8'h00, 0, q);
    chk("shifter busy", q & 8'h40, 8'h00);
    repeat (800) @(posedge ref_clk);
    acc(3'h5, 8'h00, 0, q);
    chk("tx all empty", q, 8'h60);
    far.send(8'hC3, 384);
    acc(3'h5, 8'h00, 0, q);
    chk("rx ready", q, 8'h61);
    chk("rx irq", {7'h0, intReq}, 8'h01);
    acc(3'h0, 8'h00, 0, q);
    chk("rx byte", q, 8'hC3);
    acc(3'h5, 8'h00, 0, q);
    chk("rx drained", q, 8'h60);
    acc(3'h1, 8'h02, 1, q);
    acc(3'h2, 8'h00, 0, q);
    chk("tx empty irq", q, 8'h02);
    chk("tx irq cleared", {7'h0, intReq}, 8'h00);
    far.glitch(40);
    repeat (4000) @(posedge ref_clk);
    acc(3'h5, 8'h00, 0, q);
    chk("false start", q, 8'h60);
    acc(3'h4, 8'h13, 1, q);
    repeat (2) @(posedge ref_clk);
    chk("loop outs", {3'h0, o2N, o1N, dtrN, rtsN, serTxOut}, 8'h1F);
    acc(3'h3, 8'h1E, 1, q);
    acc(3'h0, 8'h3C, 1, q);
    pollRdy();
    chk("loop tags", q & 8'h1E, 8'h00);
    acc(3'h0, 8'h00, 0, q);
    chk("loop byte", q, 8'h3C);
    rst_n = 0;
    repeat (3) @(posedge ref_clk);
    chk("tx idle in mid reset", {7'h0, serTxOut}, 8'h01);
    #2;
    rst_n = 1;
    repeat (2) @(posedge ref_clk);
    acc(3'h4, 8'h00, 0, q);
    chk("control after reset", q, 8'h00);
    wrapUp();
  end
endmodule
